/* logic/csfb_bank.sv */
// charger status registers, event flags and interrupt pulse generation
module csfb_bank
   import csfb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   // register access port from the serial bus engine
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   // live condition inputs from analog detectors (asynchronous)
   input wire logic one_shot_mode,
   input wire logic conversion_done,
   input wire logic die_heat_regulation,
   input wire logic forward_mode,
   input wire logic battery_below_min_sys,
   input wire logic input_current_loop,
   input wire logic pin_set_current_cap,
   input wire logic input_voltage_loop,
   input wire logic fast_timer_expired,
   input wire logic trickle_timer_expired,
   input wire logic precharge_timer_expired,
   input wire logic bus_watchdog_expired,
   input wire logic [1:0] charge_phase_in,
   input wire logic [2:0] source_type_in,
   input wire logic supply_overvoltage,
   input wire logic supply_sleep,
   input wire logic battery_overcurrent,
   input wire logic battery_overvoltage,
   input wire logic system_rail_short,
   input wire logic system_rail_overvoltage,
   input wire logic die_shutdown,
   input wire logic [2:0] thermistor_zone_in,
   // event mask bits from the mask register held elsewhere
   input wire logic [DATA_W-1:0] event_mask,
   output logic irq_pulse
);
   // one-bit inputs plus the three code fields (2 + 3 + 3 bits)
   localparam int unsigned NRAW = 27;

   // pack every asynchronous input into one vector for the synchroniser
   logic [NRAW-1:0] raw_in;
   logic [NRAW-1:0] meta_q;
   logic [NRAW-1:0] sync_q;
   assign raw_in = {one_shot_mode, conversion_done, die_heat_regulation, forward_mode,
                    battery_below_min_sys, input_current_loop, pin_set_current_cap,
                    input_voltage_loop, fast_timer_expired, trickle_timer_expired,
                    precharge_timer_expired, bus_watchdog_expired, charge_phase_in,
                    source_type_in, supply_overvoltage, supply_sleep, battery_overcurrent,
                    battery_overvoltage, system_rail_short, system_rail_overvoltage,
                    die_shutdown, thermistor_zone_in};

   // two-stage synchroniser; meta_q is read only by sync_q
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
      end
   end

   // synchronised names
   logic s_one_shot, s_conv_done, s_heat, s_fwd, s_below, s_icur, s_ipin, s_vin;
   logic s_tfast, s_ttrk, s_tpre, s_wd, s_ovp, s_sleep, s_bocp, s_bovp, s_sshort, s_sovp, s_tsd;
   logic [1:0] s_phase;
   logic [2:0] s_source;
   logic [2:0] s_zone;
   assign {s_one_shot, s_conv_done, s_heat, s_fwd, s_below, s_icur, s_ipin, s_vin,
           s_tfast, s_ttrk, s_tpre, s_wd, s_phase, s_source, s_ovp, s_sleep, s_bocp,
           s_bovp, s_sshort, s_sovp, s_tsd, s_zone} = sync_q;

   // live condition vector, one bit per status/event position
   logic [DATA_W-1:0] cond_live;
   always_comb begin
      cond_live = REG_RESET_VAL;
      cond_live[BIT_CONV_DONE] = s_one_shot & s_conv_done;
      cond_live[BIT_DIE_HEAT] = s_heat;
      cond_live[BIT_MIN_SYS] = s_fwd & s_below;
      cond_live[BIT_IN_CURRENT] = s_fwd & (s_icur | s_ipin);
      cond_live[BIT_IN_VOLTAGE] = s_fwd & s_vin;
      cond_live[BIT_CHG_TIMER] = s_tfast | s_ttrk | s_tpre;
      cond_live[BIT_WATCHDOG] = s_wd;
   end

   // status registers refresh every cycle, no latching
   logic [DATA_W-1:0] cond_status_q;
   logic [DATA_W-1:0] phase_status_q;
   logic [DATA_W-1:0] fault_status_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cond_status_q <= REG_RESET_VAL;
         phase_status_q <= REG_RESET_VAL;
         fault_status_q <= REG_RESET_VAL;
      end else begin
         cond_status_q <= cond_live;
         phase_status_q <= REG_RESET_VAL;
         phase_status_q[PHASE_MSB:PHASE_LSB] <= s_phase;
         phase_status_q[SOURCE_MSB:SOURCE_LSB] <= s_source;
         fault_status_q <= REG_RESET_VAL;
         fault_status_q[BIT_SUPPLY_FAULT] <= s_ovp | s_sleep;
         fault_status_q[BIT_BATT_FAULT] <= s_bocp | s_bovp;
         fault_status_q[BIT_RAIL_FAULT] <= s_sshort | s_sovp;
         fault_status_q[BIT_DIE_SHUTDOWN] <= s_tsd;
         fault_status_q[ZONE_MSB:ZONE_LSB] <= s_zone;
      end
   end

   // event detection from the previous live condition
   logic [DATA_W-1:0] cond_prev_q;
   logic [DATA_W-1:0] event_now;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cond_prev_q <= REG_RESET_VAL;
      end else begin
         cond_prev_q <= cond_live;
      end
   end

   // rising edges, except the minimum rail bit which fires on both edges
   always_comb begin
      event_now = cond_live & ~cond_prev_q;
      event_now[BIT_MIN_SYS] = cond_live[BIT_MIN_SYS] ^ cond_prev_q[BIT_MIN_SYS];
      event_now[DATA_W-1] = 1'b0;
   end

   // read decode for the data path; clear-on-read compares the address separately
   function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                 input logic [DATA_W-1:0] c,
                                                 input logic [DATA_W-1:0] p,
                                                 input logic [DATA_W-1:0] f,
                                                 input logic [DATA_W-1:0] e);
      if (a == ADDR_COND_STATUS) begin
         read_mux = c;
      end else if (a == ADDR_PHASE_STATUS) begin
         read_mux = p;
      end else if (a == ADDR_FAULT_STATUS) begin
         read_mux = f;
      end else if (a == ADDR_EVENT_FLAGS) begin
         read_mux = e;
      end else begin
         read_mux = REG_RESET_VAL;
      end
   endfunction : read_mux

   // sticky event flags; a new edge in the read cycle wins over the clear
   logic [DATA_W-1:0] event_flags_q;
   logic flag_read;
   assign flag_read = reg_rd && (reg_addr == ADDR_EVENT_FLAGS);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         event_flags_q <= REG_RESET_VAL;
      end else if (flag_read) begin
         event_flags_q <= event_now;
      end else begin
         event_flags_q <= event_flags_q | event_now;
      end
   end

   // read data register; writes are ignored since every register is read-only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= REG_RESET_VAL;
      end else if (reg_rd) begin
         reg_rdata <= read_mux(reg_addr, cond_status_q, phase_status_q, fault_status_q,
                               event_flags_q);
      end
   end

   // one-cycle interrupt pulse for each cycle with one or more new unmasked events
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_pulse <= 1'b0;
      end else begin
         irq_pulse <= |(event_now & ~event_mask);
      end
   end

   // reg_wr and reg_wdata have no effect: the bank holds no writable state
endmodule : csfb_bank

/* logic/csfb_pkg.sv */
// constants for the charger status and event-flag register bank
package csfb_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   // register addresses
   localparam logic [7:0] ADDR_COND_STATUS = 8'h1D;
   localparam logic [7:0] ADDR_PHASE_STATUS = 8'h1E;
   localparam logic [7:0] ADDR_FAULT_STATUS = 8'h1F;
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h20;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   // condition status and event flag bit positions (shared layout)
   localparam int unsigned BIT_CONV_DONE = 6;
   localparam int unsigned BIT_DIE_HEAT = 5;
   localparam int unsigned BIT_MIN_SYS = 4;
   localparam int unsigned BIT_IN_CURRENT = 3;
   localparam int unsigned BIT_IN_VOLTAGE = 2;
   localparam int unsigned BIT_CHG_TIMER = 1;
   localparam int unsigned BIT_WATCHDOG = 0;
   localparam int unsigned NUM_EVENTS = 7;
   // phase/source status fields
   localparam int unsigned PHASE_LSB = 3;
   localparam int unsigned PHASE_MSB = 4;
   localparam int unsigned SOURCE_LSB = 0;
   localparam int unsigned SOURCE_MSB = 2;
   localparam logic [1:0] PHASE_IDLE = 2'h0;
   localparam logic [1:0] PHASE_CC = 2'h1;
   localparam logic [1:0] PHASE_CV = 2'h2;
   localparam logic [1:0] PHASE_TOPOFF = 2'h3;
   localparam logic [2:0] SOURCE_NONE = 3'h0;
   localparam logic [2:0] SOURCE_UNKNOWN = 3'h4;
   // fault status bit positions
   localparam int unsigned BIT_SUPPLY_FAULT = 7;
   localparam int unsigned BIT_BATT_FAULT = 6;
   localparam int unsigned BIT_RAIL_FAULT = 5;
   localparam int unsigned BIT_DIE_SHUTDOWN = 3;
   localparam int unsigned ZONE_LSB = 0;
   localparam int unsigned ZONE_MSB = 2;
   localparam logic [2:0] ZONE_NORMAL = 3'h0;
   localparam logic [2:0] ZONE_COLD = 3'h1;
   localparam logic [2:0] ZONE_HOT = 3'h2;
   localparam logic [2:0] ZONE_COOL = 3'h3;
   localparam logic [2:0] ZONE_WARM = 3'h4;
   localparam logic [2:0] ZONE_PRECOOL = 3'h5;
   localparam logic [2:0] ZONE_PREWARM = 3'h6;
   localparam logic [2:0] ZONE_BIAS_FAULT = 3'h7;
endpackage : csfb_pkg

/* verif/csfb_bank_monitor.sv */
// port-level assertion checker for the charger status and event-flag bank
module csfb_bank_monitor
   import csfb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic die_heat_regulation,
   input wire logic one_shot_mode,
   input wire logic bus_watchdog_expired,
   input wire logic [DATA_W-1:0] event_mask,
   input wire logic irq_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // a read strobe taken at one address
   sequence rd_at(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   // the long holds cover the two-stage synchroniser plus the status register
   sequence heat_held_read;
      die_heat_regulation [*5] ##0 rd_at(ADDR_COND_STATUS);
   endsequence
   sequence cont_mode_read;
      (!one_shot_mode) [*4] ##0 rd_at(ADDR_COND_STATUS);
   endsequence
   chk_read_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
   chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h1D || reg_addr > 8'h20) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_cond_reserved: assert property (rd_at(ADDR_COND_STATUS) |=> !reg_rdata[7]) else $error("cond bit 7 set");
   chk_phase_reserved: assert property (rd_at(ADDR_PHASE_STATUS) |=> reg_rdata[7:5] == 3'h0)
      else $error("phase reserved bits set");
   chk_fault_reserved: assert property (rd_at(ADDR_FAULT_STATUS) |=> !reg_rdata[4]) else $error("fault bit 4 set");
   chk_event_reserved: assert property (rd_at(ADDR_EVENT_FLAGS) |=> !reg_rdata[7]) else $error("event bit 7 set");
   chk_cont_conv_zero: assert property (cont_mode_read |=> !reg_rdata[BIT_CONV_DONE])
      else $error("conversion bit set in continuous mode");
   chk_heat_live: assert property (heat_held_read |=> reg_rdata[BIT_DIE_HEAT]) else $error("heat status missing");
   chk_wd_irq: assert property ($rose(bus_watchdog_expired) && !event_mask[BIT_WATCHDOG] |-> ##[2:4] irq_pulse)
      else $error("no interrupt after watchdog edge");
   chk_masked_quiet: assert property ((event_mask[6:0] == 7'h7F) [*5] |-> !irq_pulse)
      else $error("interrupt while all masked");
endmodule : csfb_bank_monitor

bind csfb_bank csfb_bank_monitor csfb_bank_monitor_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .die_heat_regulation(die_heat_regulation),
   .one_shot_mode(one_shot_mode), .bus_watchdog_expired(bus_watchdog_expired), .event_mask(event_mask),
   .irq_pulse(irq_pulse));

/* verif/csfb_host.sv */
// host model that reads and writes the bank through its register access port
module csfb_host
   import csfb_pkg::*;
(
   input wire logic core_clk,
   output logic [ADDR_W-1:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // strobe for one edge; data is registered, so take it one cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      d = reg_rdata;
      reg_rd = 1'b0;
      reg_addr = ~a; // released address no longer holds its value
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~v;
   endtask : wr
endmodule : csfb_host

/* verif/tb_csfb_bank.sv */
// self-checking bench for the charger status and event-flag bank
module tb_csfb_bank
   import csfb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [18:0] lv = 19'h0;
   logic [1:0] ph = 2'h0;
   logic [2:0] src = 3'h0;
   logic [2:0] zn = 3'h0;
   logic [7:0] mask = 8'h00;
   logic [7:0] addr, wdata, rdata, d, fl;
   logic rd, wr, irq;
   int mismatches = 0;
   int cmp_count = 0;
   int irq_n = 0;
   int n0;
   // expected status per live input bit; 19 is a one-shot conversion finishing
   logic [7:0] exp_tab [0:19] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h02,
      8'h02, 8'h01, 8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h08, 8'h40};
   csfb_host csfb_host_i (.core_clk(core_clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rdata(rdata));
   csfb_bank csfb_bank_i (.core_clk(core_clk), .rst(rst), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rdata(rdata), .one_shot_mode(lv[0]), .conversion_done(lv[1]),
      .die_heat_regulation(lv[2]), .forward_mode(lv[3]), .battery_below_min_sys(lv[4]),
      .input_current_loop(lv[5]), .pin_set_current_cap(lv[6]), .input_voltage_loop(lv[7]),
      .fast_timer_expired(lv[8]), .trickle_timer_expired(lv[9]), .precharge_timer_expired(lv[10]),
      .bus_watchdog_expired(lv[11]), .supply_overvoltage(lv[12]), .supply_sleep(lv[13]),
      .battery_overcurrent(lv[14]), .battery_overvoltage(lv[15]), .system_rail_short(lv[16]),
      .system_rail_overvoltage(lv[17]), .die_shutdown(lv[18]), .charge_phase_in(ph), .source_type_in(src),
      .thermistor_zone_in(zn), .event_mask(mask), .irq_pulse(irq));
   // 125 MHz clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   // count interrupt pulses for the per-case checks
   always @(posedge core_clk) begin
      if (irq === 1'b1) irq_n <= irq_n + 1;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      csfb_host_i.rd(a, v);
      check(v, e);
   endtask : rd_chk
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   // the whole run is about 560 cycles (under 5 us); this cuts a hang short
   initial begin
      #50000;
      mismatches++;
      end_sim();
   end
   initial begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      for (int a = 8'h1C; a <= 8'h21; a++) begin
         rd_chk(8'(a), 8'h00);
         csfb_host_i.wr(8'(a), 8'hFF);
         rd_chk(8'(a), 8'h00);
      end
      $display("test reset_and_writes done");
      lv = 19'h8;
      repeat (6) @(negedge core_clk);
      csfb_host_i.rd(ADDR_EVENT_FLAGS, d);
      // forward mode stays on as the baseline; one condition at a time on top of it
      for (int i = 0; i < 20; i++) begin
         n0 = irq_n;
         fl = (i > 11 && i < 19) ? 8'h00 : exp_tab[i];
         lv = (i == 19) ? 19'hB : (19'h8 | (19'h1 << i));
         repeat (6) @(negedge core_clk);
         rd_chk((i > 11 && i < 19) ? ADDR_FAULT_STATUS : ADDR_COND_STATUS, exp_tab[i]);
         rd_chk(ADDR_EVENT_FLAGS, fl);
         check(8'(irq_n - n0), {7'h0, fl != 8'h00});
         rd_chk(ADDR_EVENT_FLAGS, 8'h00);
         lv = 19'h8;
         repeat (6) @(negedge core_clk);
         rd_chk(ADDR_EVENT_FLAGS, (i == 4) ? 8'h10 : 8'h00);
      end
      $display("test conditions_and_events done");
      n0 = irq_n;
      mask = 8'h7F;
      lv = 19'h808;
      repeat (6) @(negedge core_clk);
      check(8'(irq_n - n0), 8'h00);
      rd_chk(ADDR_EVENT_FLAGS, 8'h01);
      lv = 19'h8;
      mask = 8'h00;
      $display("test masked_event done");
      // regulation loops active without forward mode must leave bits 4:2 and their flags clear
      @(negedge core_clk);
      lv = 19'hF0;
      repeat (6) @(negedge core_clk);
      rd_chk(ADDR_COND_STATUS, 8'h00);
      rd_chk(ADDR_EVENT_FLAGS, 8'h00);
      lv = 19'h8;
      repeat (6) @(negedge core_clk);
      rd_chk(ADDR_EVENT_FLAGS, 8'h00);
      $display("test no_forward_mode done");
      for (int k = 0; k < 8; k++) begin
         ph = 2'(k);
         src = k[0] ? SOURCE_UNKNOWN : SOURCE_NONE;
         zn = 3'(k);
         repeat (6) @(negedge core_clk);
         rd_chk(ADDR_PHASE_STATUS, {3'h0, ph, src});
         rd_chk(ADDR_FAULT_STATUS, {5'h0, zn});
      end
      $display("test field_codes done");
      end_sim();
   end
endmodule : tb_csfb_bank
